// ### sequencer_pkg.sv
/*
 * Constants, types and field layout for the soft-start / skip sequencer.
 * Assumes a 100 MHz core clock; all counts are in core clock cycles.
 */
// Notes on behaviour
// - Startup end loads final on-time into soft-start
// - Soft-start releases on-time counter from zero
// - High drive lasts exactly the up-count
// - Dead time, then low drive during down-count
// - Each soft-start clock tick adds selected soft-start increment
// - Increment clocked every low pulse or every Nth
// - Reference converter ramps from zero with counter
// - Regulation active: comparator trip ends high pulse
// - Soft-start counter saturates at maximum, never wraps
// - Max on-time fault armed only at limit
// - On-time repetition disabled when soft-start begins
// - Repetition re-enabled after periodic comparator trips
// - Skip entry accepted only during high pulse
// - Skip threshold from pin or internal option
// - Skip entry ends with 3/2 low pulse
// - Below skip threshold: drivers off, idle state
// - Above threshold plus hysteresis restarts a burst
// - Burst opens with fixed low pulse, dead time
// - First burst high pulse uses reduced feedback
// - Skip request in soft-start saturates counter
// - Max on-time fault ignored during soft-start
// - Current-sense trip turns up-count into down-count
// - Burst low pulse prolonged while comparator high
`default_nettype none
package sequencer_pkg;

   // ----------------------------------------
   // Widths and timing
   // ----------------------------------------
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] MAX_ON_TIME = 12'hFFF;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DT_NS = 200;
   localparam int FIRST_LO_NS = 1000;
   localparam logic [CNT_W-1:0] DT_CYC = 12'((DT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FIRST_LO_CYC =
      12'((FIRST_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] TRIP_RUN = 2'h3;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_EXT_THR_BIT = 1;
   localparam int CTRL_INC_LSB = 2;
   localparam int CTRL_DIV_LSB = 8;
   localparam int CTRL_RED_LSB = 12;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_PHASE_LSB = 3;
   localparam int ST_REP_BIT = 6;
   localparam int ST_FAULT_BIT = 7;
   localparam int ST_BAL_BIT = 8;
   localparam int ST_SS_LSB = 16;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0, MODE_SS = 3'h1, MODE_NORM = 3'h3, MODE_SKIP = 3'h2, MODE_BURST = 3'h6
   } mode_t;
   typedef enum logic [2:0] {
      PH_OFF = 3'h0, PH_HI = 3'h1, PH_DTA = 3'h3, PH_LO = 3'h2, PH_DTB = 3'h6,
      PH_FIRST = 3'h7, PH_LAST = 3'h5
   } phase_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ontime;
      logic skip_below;
      logic skip_exit;
   } cmp_t;
   typedef struct packed {
      logic hi;
      logic lo;
   } gate_t;

endpackage : sequencer_pkg
`default_nettype wire

// ### sync2.sv
/*
 * Two flip-flop synchroniser for asynchronous comparator levels.
 * Assumes inputs are levels; the first stage is read only by the second.
 */
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int W = 3
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic [W-1:0] i_async,
   output var logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   // Hold both stages while frozen
   always_comb begin
      meta_d = i_clk_en ? i_async : meta_q;
      sync_d = i_clk_en ? meta_q : o_sync;
   end

   // Two stages
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= meta_d;
         o_sync <= sync_d;
      end
   end
endmodule : sync2
`default_nettype wire

// ### lo_pulse_divider.sv
/*
 * Divides low-side pulse starts by N for the soft-start clock.
 * Assumes i_pulse is one cycle per low pulse; N of 0 or 1 ticks every pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module lo_pulse_divider (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_clear,
   input wire logic i_pulse,
   input wire logic [3:0] i_div,
   output logic o_tick
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   // Tick on the N-th pulse, then restart the count
   always_comb begin
      o_tick = i_pulse && ((i_div <= 4'h1) || (cnt_q >= i_div - 4'h1));
      cnt_d = cnt_q;
      if (i_clear) begin
         cnt_d = 4'h0;
      end else if (o_tick) begin
         cnt_d = 4'h0;
      end else if (i_pulse) begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   // Pulse count
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= 4'h0;
      end else if (i_clk_en) begin
         cnt_q <= cnt_d;
      end
   end
endmodule : lo_pulse_divider
`default_nettype wire

// ### resonant_softstart_skip_sequencer.sv
/*
 * Soft-start and skip-mode sequencer for a half-bridge resonant controller,
 * with a classic Wishbone register slave.
 * Assumes the startup sequencer runs on the same clock and comparators are
 * asynchronous levels; on-time counts are in core clock cycles.
 */
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module resonant_softstart_skip_sequencer
   import sequencer_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire wb_req_t i_wb,
   output var logic [31:0] o_wb_dat,
   output var logic o_wb_ack,
   input wire logic i_startup_done,
   input wire logic [CNT_W-1:0] i_startup_ontime,
   input wire cmp_t i_cmp,
   output var gate_t o_gate_drive,
   output var logic [CNT_W-1:0] o_ss_dac,
   output var logic o_fb_reduce_en,
   output var logic [3:0] o_fb_reduce_code,
   output var logic o_skip_thr_ext,
   output var logic o_fault_max_on
);

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic is_low_phase(input phase_t ph);
      is_low_phase = (ph == PH_LO) || (ph == PH_FIRST) || (ph == PH_LAST);
   endfunction : is_low_phase

   function automatic logic [CNT_W-1:0] three_half(input logic [CNT_W-1:0] t);
      logic [CNT_W:0] s;
      s = {1'b0, t} + {2'b00, t[CNT_W-1:1]};
      three_half = s[CNT_W] ? MAX_ON_TIME : s[CNT_W-1:0];
   endfunction : three_half

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cmp_t cmp_s;
   logic tick;
   logic [31:0] ctrl_q, ctrl_d, rdat_d;
   logic ack_d, fault_clr, bus_req;
   mode_t mode_q, mode_d;
   phase_t phase_q, phase_d;
   logic [CNT_W-1:0] on_cnt_q, on_cnt_d, dt_cnt_q, dt_cnt_d;
   logic [CNT_W-1:0] ss_cnt_q, ss_cnt_d, dac_d, hi_time_q, hi_time_d, inc, hi_limit;
   logic [CNT_W:0] ss_sum, dac_sum;
   logic skip_pend_q, skip_pend_d, rep_en_q, rep_en_d, first_hi_q, first_hi_d;
   logic bal_q, bal_d, prol_q, prol_d, fault_d, lo_start_q, lo_start_d;
   logic [1:0] trip_run_q, trip_run_d;
   logic trip, hi_end, fault_armed, enable;
   gate_t gate_d;
   logic fb_red_d;

   // ----------------------------------------
   // Comparator synchroniser and soft-start clock
   // ----------------------------------------
   sync2 #(.W(3)) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_async(i_cmp),
      .o_sync(cmp_s)
   );

   lo_pulse_divider u_div (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_clear(mode_q == MODE_IDLE),
      .i_pulse(lo_start_q),
      .i_div(ctrl_q[CTRL_DIV_LSB +: 4]),
      .o_tick(tick)
   );

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------

   // Decode, byte-lane writes, status read, one-cycle ack
   always_comb begin
      bus_req = i_wb.cyc && i_wb.stb && !o_wb_ack;
      ack_d = bus_req;
      ctrl_d = ctrl_q;
      fault_clr = 1'b0;
      rdat_d = 32'h0000_0000;
      if (bus_req && i_wb.we && (i_wb.adr == OFS_CTRL)) begin
         for (int b = 0; b < 4; b++) begin
            if (i_wb.sel[b]) begin
               ctrl_d[8*b +: 8] = i_wb.dat[8*b +: 8];
            end
         end
      end
      if (bus_req && i_wb.we && (i_wb.adr == OFS_STATUS) && i_wb.sel[0]) begin
         fault_clr = i_wb.dat[ST_FAULT_BIT];
      end
      if (bus_req && !i_wb.we) begin
         case (i_wb.adr)
            OFS_CTRL: rdat_d = ctrl_q;
            OFS_STATUS: begin
               rdat_d[ST_MODE_LSB +: 3] = mode_q;
               rdat_d[ST_PHASE_LSB +: 3] = phase_q;
               rdat_d[ST_REP_BIT] = rep_en_q;
               rdat_d[ST_FAULT_BIT] = o_fault_max_on;
               rdat_d[ST_BAL_BIT] = bal_q;
               rdat_d[ST_SS_LSB +: CNT_W] = ss_cnt_q;
            end
            default: rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q <= CTRL_RESET;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else if (i_clk_en) begin
         ctrl_q <= ctrl_d;
         o_wb_ack <= ack_d;
         o_wb_dat <= rdat_d;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------

   // Next state of the mode and phase machines and their counters
   always_comb begin
      enable = ctrl_q[CTRL_EN_BIT];
      inc = CNT_W'(12'h001 << ctrl_q[CTRL_INC_LSB +: 3]);
      ss_sum = {1'b0, ss_cnt_q} + {1'b0, inc};
      dac_sum = {1'b0, o_ss_dac} + {1'b0, inc};
      trip = !cmp_s.ontime;
      fault_armed = (mode_q != MODE_SS) && (ss_cnt_q == MAX_ON_TIME);
      hi_limit = (mode_q == MODE_SS) ? ss_cnt_q : MAX_ON_TIME;
      hi_end = trip || (on_cnt_q >= hi_limit);
      if (rep_en_q && !first_hi_q && (hi_time_q != 12'h000) && (on_cnt_q >= hi_time_q)) begin
         hi_end = 1'b1;
      end
      if (first_hi_q) begin
         hi_end = trip || (on_cnt_q >= MAX_ON_TIME);
      end
      mode_d = mode_q;
      phase_d = phase_q;
      on_cnt_d = on_cnt_q;
      dt_cnt_d = dt_cnt_q;
      ss_cnt_d = ss_cnt_q;
      dac_d = o_ss_dac;
      hi_time_d = hi_time_q;
      skip_pend_d = skip_pend_q;
      rep_en_d = rep_en_q;
      trip_run_d = trip_run_q;
      first_hi_d = first_hi_q;
      bal_d = bal_q;
      prol_d = prol_q;
      lo_start_d = 1'b0;
      fault_d = o_fault_max_on && !fault_clr;
      case (phase_q)
         PH_OFF: begin
            if ((mode_q == MODE_IDLE) && enable && i_startup_done) begin
               ss_cnt_d = i_startup_ontime;
               dac_d = 12'h000;
               mode_d = MODE_SS;
               phase_d = PH_HI;
               on_cnt_d = 12'h000;
               rep_en_d = 1'b0;
               trip_run_d = 2'h0;
            end else if ((mode_q == MODE_SKIP) && cmp_s.skip_exit) begin
               mode_d = MODE_BURST;
               phase_d = PH_FIRST;
               dt_cnt_d = FIRST_LO_CYC;
               bal_d = 1'b0;
            end
         end
         PH_HI: begin
            if (on_cnt_q != MAX_ON_TIME) begin
               on_cnt_d = on_cnt_q + 12'h001;
            end
            if (cmp_s.skip_below && ((mode_q == MODE_NORM) || (mode_q == MODE_BURST))) begin
               skip_pend_d = 1'b1;
            end
            if (fault_armed && (on_cnt_q >= MAX_ON_TIME)) begin
               fault_d = 1'b1;
            end
            if (hi_end) begin
               phase_d = PH_DTA;
               dt_cnt_d = DT_CYC;
               hi_time_d = on_cnt_q;
               first_hi_d = 1'b0;
               if (trip && !first_hi_q) begin
                  trip_run_d = (trip_run_q == TRIP_RUN) ? TRIP_RUN : trip_run_q + 2'h1;
                  if (trip_run_q >= TRIP_RUN - 2'h1) begin
                     rep_en_d = 1'b1;
                  end
               end else begin
                  trip_run_d = 2'h0;
               end
            end
         end
         PH_DTA: begin
            if (dt_cnt_q <= 12'h001) begin
               if (skip_pend_q) begin
                  phase_d = PH_LAST;
                  on_cnt_d = three_half(hi_time_q);
                  skip_pend_d = 1'b0;
               end else begin
                  phase_d = PH_LO;
                  lo_start_d = 1'b1;
                  prol_d = 1'b0;
               end
            end else begin
               dt_cnt_d = dt_cnt_q - 12'h001;
            end
         end
         PH_LO: begin
            if (on_cnt_q != 12'h000) begin
               on_cnt_d = on_cnt_q - 12'h001;
            end else if ((mode_q == MODE_BURST) && cmp_s.ontime && !bal_q) begin
               prol_d = 1'b1;
            end else begin
               if ((mode_q == MODE_BURST) && !prol_q) begin
                  bal_d = 1'b1;
               end
               phase_d = PH_DTB;
               dt_cnt_d = DT_CYC;
            end
         end
         PH_DTB: begin
            if (dt_cnt_q <= 12'h001) begin
               phase_d = PH_HI;
               on_cnt_d = 12'h000;
            end else begin
               dt_cnt_d = dt_cnt_q - 12'h001;
            end
         end
         PH_FIRST: begin
            if (dt_cnt_q <= 12'h001) begin
               phase_d = PH_DTB;
               dt_cnt_d = DT_CYC;
               first_hi_d = 1'b1;
            end else begin
               dt_cnt_d = dt_cnt_q - 12'h001;
            end
         end
         PH_LAST: begin
            if (on_cnt_q != 12'h000) begin
               on_cnt_d = on_cnt_q - 12'h001;
            end else begin
               phase_d = PH_OFF;
               mode_d = MODE_SKIP;
            end
         end
         default: phase_d = PH_OFF;
      endcase
      // Soft-start counter and reference ramp, stepped by the divided low pulses
      if (tick && (mode_q != MODE_IDLE)) begin
         ss_cnt_d = ss_sum[CNT_W] ? MAX_ON_TIME : ss_sum[CNT_W-1:0];
         dac_d = dac_sum[CNT_W] ? MAX_ON_TIME : dac_sum[CNT_W-1:0];
         if ((mode_q == MODE_SS) && (ss_sum >= {1'b0, MAX_ON_TIME})) begin
            mode_d = MODE_NORM;
         end
      end
      // Skip request while soft-starting ends soft-start at once
      if ((mode_q == MODE_SS) && cmp_s.skip_below) begin
         ss_cnt_d = MAX_ON_TIME;
         dac_d = MAX_ON_TIME;
         mode_d = MODE_NORM;
      end
      // Disabling drops both drives and returns to idle
      if (!enable) begin
         mode_d = MODE_IDLE;
         phase_d = PH_OFF;
         skip_pend_d = 1'b0;
         first_hi_d = 1'b0;
      end
      gate_d.hi = (phase_d == PH_HI);
      gate_d.lo = is_low_phase(phase_d);
      fb_red_d = (phase_d == PH_HI) && first_hi_d;
   end

   // Sequencer registers; outputs come straight from these
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_q <= MODE_IDLE;
         phase_q <= PH_OFF;
         on_cnt_q <= 12'h000;
         dt_cnt_q <= 12'h000;
         ss_cnt_q <= 12'h000;
         hi_time_q <= 12'h000;
         skip_pend_q <= 1'b0;
         rep_en_q <= 1'b0;
         trip_run_q <= 2'h0;
         first_hi_q <= 1'b0;
         bal_q <= 1'b0;
         prol_q <= 1'b0;
         lo_start_q <= 1'b0;
         o_gate_drive <= '0;
         o_ss_dac <= 12'h000;
         o_fb_reduce_en <= 1'b0;
         o_fb_reduce_code <= 4'h0;
         o_skip_thr_ext <= 1'b0;
         o_fault_max_on <= 1'b0;
      end else if (i_clk_en) begin
         mode_q <= mode_d;
         phase_q <= phase_d;
         on_cnt_q <= on_cnt_d;
         dt_cnt_q <= dt_cnt_d;
         ss_cnt_q <= ss_cnt_d;
         hi_time_q <= hi_time_d;
         skip_pend_q <= skip_pend_d;
         rep_en_q <= rep_en_d;
         trip_run_q <= trip_run_d;
         first_hi_q <= first_hi_d;
         bal_q <= bal_d;
         prol_q <= prol_d;
         lo_start_q <= lo_start_d;
         o_gate_drive <= gate_d;
         o_ss_dac <= dac_d;
         o_fb_reduce_en <= fb_red_d;
         o_fb_reduce_code <= ctrl_d[CTRL_RED_LSB +: 4];
         o_skip_thr_ext <= ctrl_d[CTRL_EXT_THR_BIT];
         o_fault_max_on <= fault_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   sequence lo_quiet_s;
      !o_gate_drive.lo [*8];
   endsequence

   sequence hi_quiet_s;
      !o_gate_drive.hi [*8];
   endsequence

   no_overlap_a: assert property (!(o_gate_drive.hi && o_gate_drive.lo))
      else $error("high and low drive both active");
   gap_after_hi_a: assert property ($fell(o_gate_drive.hi) |-> lo_quiet_s)
      else $error("low drive too soon after high");
   gap_after_lo_a: assert property ($fell(o_gate_drive.lo) |-> hi_quiet_s)
      else $error("high drive too soon after low");
   hi_from_zero_a: assert property ($rose(o_gate_drive.hi) |-> on_cnt_q == 12'h000)
      else $error("up-count did not start from zero");
   ss_load_a: assert property ($rose(mode_q == MODE_SS)
      |-> ss_cnt_q == $past(i_startup_ontime) && o_ss_dac == 12'h000 && !rep_en_q)
      else $error("soft-start not loaded from startup on-time");
   ss_saturate_a: assert property ((ss_cnt_q == MAX_ON_TIME) && (mode_q != MODE_IDLE)
      |=> ss_cnt_q == MAX_ON_TIME)
      else $error("soft-start counter left its maximum");
   fault_gate_a: assert property ($rose(o_fault_max_on)
      |-> $past(mode_q) != MODE_SS && $past(ss_cnt_q) == MAX_ON_TIME)
      else $error("fault raised while not armed");
   skip_sync_a: assert property ($rose(skip_pend_q) |-> $past(phase_q) == PH_HI)
      else $error("skip request taken outside high pulse");
   last_len_a: assert property ($rose(phase_q == PH_LAST)
      |-> on_cnt_q == three_half(hi_time_q))
      else $error("last low pulse not 3/2 of high pulse");
   skip_idle_a: assert property (mode_q == MODE_SKIP
      |-> !o_gate_drive.hi && !o_gate_drive.lo)
      else $error("driver active in skip idle");
   burst_open_a: assert property ($rose(mode_q == MODE_BURST)
      |-> phase_q == PH_FIRST && o_gate_drive.lo && dt_cnt_q == FIRST_LO_CYC)
      else $error("burst did not open with low pulse");

endmodule : resonant_softstart_skip_sequencer
`default_nettype wire

// ### cmp_partner.sv
/* Comparator model at the sequencer's far side.
   Assumes gate levels from the design and trip timing set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module cmp_partner
   import sequencer_pkg::*;
(
   input wire logic i_core_clk,
   input wire gate_t i_gate,
   input wire logic i_trip_en,
   input wire logic [11:0] i_trip_cyc,
   input wire logic i_lo_hold,
   input wire logic i_below,
   input wire logic i_exit,
   output var cmp_t o_cmp
);
   logic [11:0] cnt_q;
   // Length of the high-side pulse so far
   always_ff @(posedge i_core_clk) cnt_q <= i_gate.hi ? cnt_q + 12'h001 : 12'h000;
   // Trip after the set on-time, held high between pulses on request
   always_comb begin
      o_cmp.ontime = i_gate.hi ? !(i_trip_en && cnt_q >= i_trip_cyc) : i_lo_hold;
      o_cmp.skip_below = i_below;
      o_cmp.skip_exit = i_exit;
   end
endmodule : cmp_partner
`default_nettype wire

// ### resonant_softstart_skip_sequencer_tb_top.sv
/* Self-checking bench for the soft-start and skip sequencer.
   Assumes cmp_partner.sv as comparators and a 100 MHz core clock. */
`timescale 1ns/100ps
`default_nettype none
module resonant_softstart_skip_sequencer_tb_top
   import sequencer_pkg::*;
;
   logic clk, rst_b, ack, sdone, red_en, thr_ext, fault;
   logic trip_en, lo_hold, below, exitl, clk_en;
   logic [11:0] sont, dac, trip_cyc;
   logic [3:0] red_code;
   logic [31:0] rdat, st;
   wb_req_t wb_q;
   cmp_t cmp;
   gate_t gate;
   int fails, samples_checked, h, l, d;

   resonant_softstart_skip_sequencer resonant_softstart_skip_sequencer_inst (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_wb(wb_q),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_startup_done(sdone),
      .i_startup_ontime(sont), .i_cmp(cmp), .o_gate_drive(gate), .o_ss_dac(dac),
      .o_fb_reduce_en(red_en), .o_fb_reduce_code(red_code),
      .o_skip_thr_ext(thr_ext), .o_fault_max_on(fault));
   cmp_partner cmp_partner_inst (
      .i_core_clk(clk), .i_gate(gate), .i_trip_en(trip_en), .i_trip_cyc(trip_cyc),
      .i_lo_hold(lo_hold), .i_below(below), .i_exit(exitl), .o_cmp(cmp));

   // ---------------------------------------
   // Shared tasks
   // ---------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dt,
                     output logic [31:0] q);
      wb_q <= '{1'b1, 1'b1, we, adr, 4'hF, dt};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      wb_q <= '0;
      @(posedge clk);
   endtask : wb

   function automatic logic drv(input bit lo_side);
      return lo_side ? gate.lo : gate.hi;
   endfunction : drv

   // Width of the next pulse on one side, then the gap after it
   task automatic pulse(input bit lo_side, output int n, output int g);
      n = 0;
      g = 0;
      while (drv(lo_side) !== 1'b1) @(posedge clk);
      while (drv(lo_side) === 1'b1) begin
         n++;
         @(posedge clk);
      end
      while (gate === 2'b00 && g < 400) begin
         g++;
         @(posedge clk);
      end
   endtask : pulse

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   // ---------------------------------------
   // Scenarios
   // ---------------------------------------
   task automatic t_regs;
      check(gate, 32'h0);
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check(st[2:0], MODE_IDLE);
      wb(1'b0, 4'h8, 32'h0, st);
      check(st, 32'h0);
      wb(1'b1, OFS_CTRL, 32'h0000_5207, st);
      wb(1'b0, OFS_CTRL, 32'h0, st);
      check(st, 32'h0000_5207);
      check(red_code, 4'h5);
      check(thr_ext, 1'b1);
   endtask : t_regs

   task automatic t_soft;
      sdone <= 1'b1;
      @(posedge clk);
      sdone <= 1'b0;
      while (gate.hi !== 1'b1) @(posedge clk);
      check(dac, 12'h000);
      repeat (4) begin
         pulse(1'b0, h, d);
         check(d, 20);
         pulse(1'b1, l, d);
         check(l, h + 1);
         check(d, 20);
      end
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check(st[27:16], 12'h014);
      check(st[6:0], {1'b0, PH_HI, MODE_SS});
      check(dac, 12'h004);
   endtask : t_soft

   task automatic t_sat;
      check(fault, 1'b0);
      // Skip request inside a low pulse, so no skip entry is latched
      while (gate.lo !== 1'b1) @(posedge clk);
      below <= 1'b1;
      repeat (3) @(posedge clk);
      below <= 1'b0;
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check({st[27:16], st[2:0]}, {MAX_ON_TIME, MODE_NORM});
      check(dac, MAX_ON_TIME);
      pulse(1'b1, l, d);
      pulse(1'b0, h, d);
      check(fault, 1'b1);
      wb(1'b1, OFS_STATUS, 32'h80, st);
      check(fault, 1'b0);
   endtask : t_sat

   task automatic t_norm;
      trip_en <= 1'b1;
      repeat (3) begin
         pulse(1'b0, h, d);
         pulse(1'b1, l, d);
      end
      check(h < 40, 1'b1);
      check(l, h + 1);
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check(st[6], 1'b1);
   endtask : t_norm

   task automatic t_skip;
      while (gate.lo !== 1'b1) @(posedge clk);
      below <= 1'b1;
      repeat (10) @(posedge clk);
      below <= 1'b0;
      pulse(1'b0, h, d);
      pulse(1'b1, l, d);
      check(l, h + 1);
      below <= 1'b1;
      pulse(1'b0, h, d);
      pulse(1'b1, l, d);
      check(l >= 3 * h / 2 && l <= 3 * h / 2 + 2, 1'b1);
      check(d, 400);
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check(st[2:0], MODE_SKIP);
      below <= 1'b0;
   endtask : t_skip

   task automatic t_burst;
      exitl <= 1'b1;
      pulse(1'b1, l, d);
      check(l, 100);
      check(d, 20);
      check(red_en, 1'b1);
      exitl <= 1'b0;
      pulse(1'b0, h, d);
      check(h < 40, 1'b1);
      check(red_en, 1'b0);
      repeat (3 * h) @(posedge clk);
      check(gate, 2'b01);
      // Frozen, a dropped comparator must not end the prolonged low pulse
      lo_hold <= 1'b0;
      clk_en <= 1'b0;
      repeat (5) @(posedge clk);
      check(gate, 2'b01);
      clk_en <= 1'b1;
      repeat (4) @(posedge clk);
      check(gate, 2'b00);
      wb(1'b0, OFS_STATUS, 32'h0, st);
      check(st[2:0], MODE_BURST);
      wb(1'b1, OFS_CTRL, 32'h0, st);
      check(gate, 2'b00);
   endtask : t_burst

   // ---------------------------------------
   // Clock, overlap watch, sequence, watchdog
   // ---------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(negedge clk) if (gate === 2'b11) check(gate, 2'b00);

   initial begin
      rst_b = 1'b0;
      wb_q = '0;
      sdone = 1'b0;
      sont = 12'h010;
      trip_en = 1'b0;
      trip_cyc = 12'h01E;
      lo_hold = 1'b1;
      clk_en = 1'b1;
      below = 1'b0;
      exitl = 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_regs();
      t_soft();
      t_sat();
      t_norm();
      t_skip();
      t_burst();
      give_verdict();
   end

   initial begin
      #600000;
      fails++;
      give_verdict();
   end
endmodule : resonant_softstart_skip_sequencer_tb_top
`default_nettype wire
